// file: epf_frame_lut.sv
// Pixel FIFO and command interpreter for frame load and waveform tables
`timescale 1ns/1ps
`default_nettype none

module epf_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  // Filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                rdy;
  } epf_fifo_t;
  epf_fifo_t s_q, s_d;
  logic push, pop;

  // Handshakes on both sides
  assign push      = in_valid && s_q.rdy;
  assign pop       = out_valid && out_ready;
  assign in_ready  = s_q.rdy;
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rp];

  // Pointer, count and registered full flag
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    s_d.rdy = (s_d.cnt != (AW+1)'(D));
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q     <= '0;
      s_q.rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : epf_fifo

module epf_frame_lut import epf_pkg::*; #(
  parameter int PIXEL_BYTES = EPF_PIXEL_BYTES,
  parameter int CW          = 16
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          sys_rst,
  // Host byte stream from the serial port
  input  wire logic          host_valid,
  input  wire logic          command_or_parameter_select,
  input  wire logic [7:0]    host_byte,
  output logic               host_ready,
  // Mode and status
  input  wire logic          colour_mode_select,
  output logic               busy_n_q,
  output logic [7:0]         stop_status_q,
  // Power and refresh steps
  output logic               power_on_step_q,
  output logic               display_refresh_step_q,
  output logic               power_off_step_q,
  output logic               deep_sleep_step_q,
  input  wire logic          step_done,
  // Frame memory write port
  output logic               fm_valid_q,
  input  wire logic          fm_ready,
  output logic               fm_red_plane_q,
  output logic [CW-1:0]      fm_addr_q,
  output logic [7:0]         fm_data_q,
  // Table read port
  input  wire logic [1:0]    rd_tbl,
  input  wire logic [2:0]    rd_group,
  input  wire logic [2:0]    rd_item,
  output logic [7:0]         rd_byte_q,
  output logic [1:0]         rd_level_q,
  output logic [5:0]         rd_frames_q,
  output logic [7:0]         rd_repeat_q,
  output logic               rd_in_use_q,
  output logic               rd_com_float_q,
  output logic [3:0]         groups_used_q
);
  localparam int FW = 1 + CW + 8;

  typedef struct packed {
    epf_seq_t                  seq;
    logic                      to_sleep;
    logic                      auto_run;
    logic [7:0]                cmd;
    logic [7:0]                auto_code;
    logic [5:0]                idx;
    logic [CW-1:0]             pix_cnt;
    logic [7:0]                stop_status;
    logic                      busy_n;
    logic                      fm_valid;
    logic                      fm_red;
    logic [CW-1:0]             fm_addr;
    logic [7:0]                fm_data;
    logic [7:0]                rd_byte;
    logic [1:0]                rd_level;
    logic [5:0]                rd_frames;
    logic [7:0]                rd_repeat;
    logic                      rd_in_use;
    logic                      rd_float;
    logic [3:0]                groups;
    logic [EPF_TABLES-1:0][EPF_TABLE_MAX-1:0][7:0] lut;
  } epf_state_t;

  epf_state_t s_q, s_d;

  // Byte position of an item in a table
  function automatic logic [5:0] byte_index(input logic [2:0] g,
                                            input logic [2:0] it);
    return 6'({3'h0, g} * EPF_GROUP_BYTES + {3'h0, it});
  endfunction : byte_index

  // Groups executed for a table in a colour mode
  function automatic logic [3:0] groups_for(input logic [1:0] tbl,
                                            input logic       bw);
    if (tbl == EPF_TBL_WW) begin
      return bw ? EPF_GROUPS_BW : EPF_GROUPS_NONE;  // see [R18] see [R17]
    end
    if (tbl == EPF_TBL_COM || tbl == EPF_TBL_BWR) begin
      return bw ? EPF_GROUPS_BW : EPF_GROUPS_FULL;  // see [R16]
    end
    return EPF_GROUPS_NONE;
  endfunction : groups_for

  // Bytes a table accepts
  function automatic logic [5:0] table_bytes(input logic [7:0] c);
    return (c == EPF_CMD_LUT_WW) ? EPF_WW_BYTES : EPF_FULL_BYTES;
  endfunction : table_bytes

  logic          take;
  logic          is_cmd;
  logic          is_par;
  logic          asleep;
  logic          pix_push;
  logic          fifo_rdy;
  logic          fifo_out_valid;
  logic          fifo_pop;
  logic [FW-1:0] fifo_wdata;
  logic [FW-1:0] fifo_rdata;
  logic [1:0]    wr_tbl;
  logic [5:0]    rd_idx;

  // Byte acceptance; host stalls while the pixel FIFO is full
  assign take     = host_valid && fifo_rdy;
  assign asleep   = (s_q.seq == EPF_SLEEP);
  assign is_cmd   = take && !command_or_parameter_select && !asleep;
  assign is_par   = take && command_or_parameter_select && !asleep;
  assign pix_push = is_par && (s_q.cmd == EPF_CMD_FRAME2);  // see [R01]
  // Red plane in black/white/red mode, new plane in black/white
  assign fifo_wdata = {!colour_mode_select, s_q.pix_cnt, host_byte};  // see [R03]
  assign fifo_pop   = !s_q.fm_valid || fm_ready;
  assign wr_tbl     = (s_q.cmd == EPF_CMD_LUT_COM) ? EPF_TBL_COM :
                      (s_q.cmd == EPF_CMD_LUT_WW)  ? EPF_TBL_WW  : EPF_TBL_BWR;
  assign rd_idx     = byte_index(rd_group, rd_item);

  epf_fifo #(
    .W (FW),
    .D (EPF_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .in_valid  (pix_push),
    .in_ready  (fifo_rdy),
    .in_data   (fifo_wdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_rdata)
  );

  // Command decode, table loads, sequencer and read port
  always_comb begin
    s_d = s_q;
    if (is_cmd) begin
      s_d.cmd = host_byte;
      s_d.idx = '0;
      if (host_byte == EPF_CMD_FRAME2) begin
        s_d.pix_cnt = '0;
      end
      if (host_byte == EPF_CMD_DATA_STOP) begin
        s_d.stop_status = '0;
        s_d.stop_status[EPF_FLAG_BIT] =
          (s_q.pix_cnt == CW'(PIXEL_BYTES));  // see [R20]
        if (s_q.pix_cnt == CW'(PIXEL_BYTES) && s_q.seq == EPF_IDLE) begin
          s_d.seq      = EPF_DRF;  // see [R02]
          s_d.auto_run = 1'b0;
        end
      end
    end
    if (is_par) begin
      unique case (s_q.cmd)
        EPF_CMD_FRAME2: begin
          if (s_q.pix_cnt != '1) begin
            s_d.pix_cnt = s_q.pix_cnt + 1'b1;
          end
        end
        EPF_CMD_AUTO: begin
          if (s_q.busy_n && s_q.seq == EPF_IDLE) begin  // see [R07]
            if (host_byte == EPF_AUTO_REFRESH ||
                host_byte == EPF_AUTO_SLEEP) begin  // see [R22]
              s_d.auto_code = host_byte;
              s_d.seq       = EPF_PON;  // see [R05] see [R06]
              s_d.auto_run  = 1'b1;
              s_d.to_sleep  = (host_byte == EPF_AUTO_SLEEP);
            end
          end
        end
        EPF_CMD_LUT_COM, EPF_CMD_LUT_WW, EPF_CMD_LUT_BWR: begin
          // Arrival order fills groups; surplus bytes dropped
          if (s_q.idx < table_bytes(s_q.cmd)) begin  // see [R09]
            s_d.lut[wr_tbl][s_q.idx] = host_byte;  // see [R08] see [R19]
            s_d.idx = s_q.idx + 1'b1;  // see [R22]
          end
        end
        default: begin
        end
      endcase
    end
    // Steps chain on completion without host help
    if (step_done) begin
      unique case (s_q.seq)
        EPF_PON:  s_d.seq = EPF_DRF;  // see [R04]
        EPF_DRF:  s_d.seq = s_q.auto_run ? EPF_POF : EPF_IDLE;
        EPF_POF:  s_d.seq = s_q.to_sleep ? EPF_DEEP_SLEEP_STEP : EPF_IDLE;
        EPF_DEEP_SLEEP_STEP: s_d.seq = EPF_SLEEP;
        // Idle and sleep ignore a stray done so a start in this cycle survives
        default: begin
        end  // see [R21]
      endcase
    end
    s_d.busy_n = (s_d.seq == EPF_IDLE);
    // Frame memory output stage
    if (fifo_pop) begin
      s_d.fm_valid = fifo_out_valid;
      s_d.fm_red   = fifo_rdata[FW-1];
      s_d.fm_addr  = fifo_rdata[FW-2:8];
      s_d.fm_data  = fifo_rdata[7:0];
    end
    // Decoded table view
    s_d.rd_byte   = (rd_tbl <= EPF_TBL_BWR && rd_item <= EPF_ITEM_ST2_RPT) ?
                    s_q.lut[rd_tbl][rd_idx] : 8'h00;
    s_d.rd_level  = s_d.rd_byte[EPF_LVL_MSB:EPF_LVL_LSB];  // see [R10]
    s_d.rd_frames = s_d.rd_byte[EPF_FRM_MSB:0];  // see [R12]
    s_d.rd_repeat = (rd_item == EPF_ITEM_GRP_RPT ||
                     rd_item >= EPF_ITEM_ST1_RPT) ? s_d.rd_byte : 8'h00;  // see [R11] see [R13]
    if (rd_item != EPF_ITEM_GRP_RPT && rd_item <= EPF_ITEM_PH_LAST) begin
      s_d.rd_float = (rd_tbl == EPF_TBL_COM) &&
                     (s_d.rd_level == EPF_COM_FLOAT);  // see [R14]
    end else begin
      s_d.rd_level  = EPF_SRC_GND;  // see [R15]
      s_d.rd_frames = '0;
      s_d.rd_float  = 1'b0;
    end
    s_d.groups    = groups_for(rd_tbl, colour_mode_select);
    s_d.rd_in_use = ({1'b0, rd_group} < s_d.groups);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q           <= '0;
      s_q.seq       <= EPF_IDLE;
      s_q.busy_n    <= 1'b1;
      s_q.auto_code <= EPF_AUTO_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs from registered state
  assign host_ready             = fifo_rdy;
  assign busy_n_q               = s_q.busy_n;
  assign stop_status_q          = s_q.stop_status;
  assign power_on_step_q        = (s_q.seq == EPF_PON);
  assign display_refresh_step_q = (s_q.seq == EPF_DRF);
  assign power_off_step_q       = (s_q.seq == EPF_POF);
  assign deep_sleep_step_q      = (s_q.seq == EPF_DEEP_SLEEP_STEP);
  assign fm_valid_q             = s_q.fm_valid;
  assign fm_red_plane_q         = s_q.fm_red;
  assign fm_addr_q              = s_q.fm_addr;
  assign fm_data_q              = s_q.fm_data;
  assign rd_byte_q              = s_q.rd_byte;
  assign rd_level_q             = s_q.rd_level;
  assign rd_frames_q            = s_q.rd_frames;
  assign rd_repeat_q            = s_q.rd_repeat;
  assign rd_in_use_q            = s_q.rd_in_use;
  assign rd_com_float_q         = s_q.rd_float;
  assign groups_used_q          = s_q.groups;

  // Checks on the interpreter
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  logic auto_par;
  assign auto_par = is_par && s_q.cmd == EPF_CMD_AUTO;

  chk_auto_busy_hold: assert property (  // see [R07]
    auto_par && !busy_n_q |=> $stable(s_q.auto_code))
    else $error("auto code taken while busy");
  chk_auto_a5_run: assert property (  // see [R05]
    auto_par && busy_n_q && host_byte == EPF_AUTO_REFRESH
    |=> power_on_step_q && !s_q.to_sleep && !busy_n_q)
    else $error("A5 did not start power on");
  chk_auto_a7_run: assert property (  // see [R06]
    auto_par && busy_n_q && host_byte == EPF_AUTO_SLEEP
    |=> power_on_step_q && s_q.to_sleep)
    else $error("A7 did not start sleep run");
  chk_step_chain: assert property (  // see [R04]
    power_on_step_q && step_done |=> display_refresh_step_q)
    else $error("refresh did not follow power on");
  chk_refresh_off: assert property (  // see [R05]
    display_refresh_step_q && s_q.auto_run && step_done |=> power_off_step_q)
    else $error("power off did not follow refresh");
  // Refresh start, pixel addresses and table bounds
  chk_stop_refresh: assert property (  // see [R02]
    is_cmd && host_byte == EPF_CMD_DATA_STOP && busy_n_q &&
    s_q.pix_cnt == CW'(PIXEL_BYTES) |=> display_refresh_step_q && !busy_n_q)
    else $error("complete frame did not start refresh");
  chk_pix_addr: assert property (  // see [R01]
    pix_push && fifo_rdy && s_q.pix_cnt != '1 |=> s_q.pix_cnt == CW'($past(s_q.pix_cnt) + 1'b1))
    else $error("pixel address did not advance");
  chk_ww_bound: assert property (  // see [R17] see [R09]
    is_par && s_q.cmd == EPF_CMD_LUT_WW && s_q.idx >= EPF_WW_BYTES |=> $stable(s_q.lut))
    else $error("white table overrun stored");
  chk_sleep_sticky: assert property (  // see [R21]
    s_q.seq == EPF_SLEEP |=> s_q.seq == EPF_SLEEP && !busy_n_q)
    else $error("left deep sleep without reset");
  chk_auto_bad_code: assert property (  // see [R22]
    auto_par && busy_n_q && host_byte != EPF_AUTO_REFRESH &&
    host_byte != EPF_AUTO_SLEEP |=> busy_n_q)
    else $error("unknown auto code started run");
  chk_stop_flag: assert property (  // see [R20]
    is_cmd && host_byte == EPF_CMD_DATA_STOP |=>
    stop_status_q[EPF_FLAG_BIT] == ($past(s_q.pix_cnt) == CW'(PIXEL_BYTES)))
    else $error("data stop flag wrong");
  chk_plane_mode: assert property (  // see [R03]
    pix_push && fifo_rdy |-> fifo_wdata[FW-1] == !colour_mode_select)
    else $error("pixel plane does not follow mode");
  chk_ww_groups: assert property (  // see [R18]
    rd_tbl == EPF_TBL_WW |=> groups_used_q ==
    ($past(colour_mode_select) ? EPF_GROUPS_BW : EPF_GROUPS_NONE))
    else $error("white table group count wrong");
  chk_lut_store: assert property (  // see [R08]
    is_par && s_q.cmd == EPF_CMD_LUT_COM && s_q.idx < EPF_FULL_BYTES
    |=> s_q.lut[EPF_TBL_COM][$past(s_q.idx)] == $past(host_byte))
    else $error("table byte not stored");

  cov_sleep_run: cover property (deep_sleep_step_q && step_done);
  cov_full_frame: cover property (stop_status_q[EPF_FLAG_BIT]);
  cov_fifo_full: cover property (host_valid && !fifo_rdy);
  cov_refresh_run: cover property (power_off_step_q && step_done && !s_q.to_sleep);
  cov_busy_reject: cover property (auto_par && !busy_n_q);
endmodule : epf_frame_lut

`default_nettype wire

// file: epf_panel_model.sv
// Behavioural panel side: frame memory acceptance and power/refresh step timing
`timescale 1ns/1ps
`default_nettype none

module epf_panel_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Bench controls
  input  wire logic       stall,
  input  wire logic [3:0] step_delay,
  // Step handshake
  input  wire logic [3:0] steps,
  output logic            step_done,
  // Frame memory acceptance
  output logic            fm_ready
);
  logic [3:0] wait_q;
  logic [3:0] prev_q;

  // Frame memory refuses writes while stalled
  assign fm_ready = ~stall;

  // Each new step is finished after a delay chosen when it starts
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wait_q    <= 4'h0;
      prev_q    <= 4'h0;
      step_done <= 1'b0;
    end else begin
      prev_q    <= steps;
      step_done <= 1'b0;
      if (steps != 4'h0 && steps != prev_q) begin
        wait_q <= step_delay;
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
        step_done <= (wait_q == 4'h1); // One-cycle done pulse
      end
    end
  end
endmodule : epf_panel_model

`default_nettype wire

// file: epf_pkg.sv
// Constants and types for the frame load and waveform table block
// Function
// [R01] Parameter bytes after 13H are pixel data, eight per byte, first in D7.
// [R02] Host sends 11H after the last pixel byte before any panel drive.
// [R03] Second frame goes to new plane in black/white, red plane otherwise.
// [R04] Automatic sequence steps run back to back with no host command.
// [R05] 17H with A5H runs power on, refresh, power off.
// [R06] 17H with A7H runs power on, refresh, power off, deep sleep.
// [R07] Automatic sequence accepted only while busy_n is high.
// [R08] 20H stores its bytes in arrival order as common table.
// [R09] Full tables hold eight groups of seven bytes, fifty-six bytes.
// [R10] Phase byte: level code in bits 7:6, frame count in 5:0.
// [R11] First group byte is the group repeat count, zero is none.
// [R12] Phase frame count holds a phase 0 to 63 frames.
// [R13] Bytes six and seven give state one and state two repeats.
// [R14] Common codes: offset, high, low, floating.
// [R15] Source codes: ground, positive, negative, red positive.
// [R16] Mode bit 0 uses eight groups, mode bit 1 uses six.
// [R17] 21H loads white-to-white table of six groups.
// [R18] White-to-white table used only in black/white mode.
// [R19] 22H loads eight-group black-to-white or red table.
// [R20] Data stop reports bit 7 set when a whole frame arrived.
// [R21] Deep sleep is left only through reset.
// [R22] Unknown auto codes ignored; unwritten table bytes keep old values.
// [R23] Host sends pixel count over eight bytes per frame.
package epf_pkg;
  // Command codes
  localparam logic [7:0] EPF_CMD_DATA_STOP = 8'h11;
  localparam logic [7:0] EPF_CMD_FRAME2    = 8'h13;
  localparam logic [7:0] EPF_CMD_AUTO      = 8'h17;
  localparam logic [7:0] EPF_CMD_LUT_COM   = 8'h20;
  localparam logic [7:0] EPF_CMD_LUT_WW    = 8'h21;
  localparam logic [7:0] EPF_CMD_LUT_BWR   = 8'h22;
  // Automatic sequence codes
  localparam logic [7:0] EPF_AUTO_REFRESH  = 8'hA5;
  localparam logic [7:0] EPF_AUTO_SLEEP    = 8'hA7;
  localparam logic [7:0] EPF_AUTO_RESET    = 8'hA5;
  // Table geometry
  localparam logic [5:0] EPF_GROUP_BYTES   = 6'h07;
  localparam logic [5:0] EPF_FULL_BYTES    = 6'h38;
  localparam logic [5:0] EPF_WW_BYTES      = 6'h2A;
  localparam logic [3:0] EPF_GROUPS_FULL   = 4'h8;
  localparam logic [3:0] EPF_GROUPS_BW     = 4'h6;
  localparam logic [3:0] EPF_GROUPS_NONE   = 4'h0;
  localparam int         EPF_TABLES        = 3;
  localparam int         EPF_TABLE_MAX     = 56;
  // Item positions inside a group
  localparam logic [2:0] EPF_ITEM_GRP_RPT  = 3'h0;
  localparam logic [2:0] EPF_ITEM_PH_LAST  = 3'h4;
  localparam logic [2:0] EPF_ITEM_ST1_RPT  = 3'h5;
  localparam logic [2:0] EPF_ITEM_ST2_RPT  = 3'h6;
  // Phase byte fields and status bit
  localparam int         EPF_LVL_MSB       = 7;
  localparam int         EPF_LVL_LSB       = 6;
  localparam int         EPF_FRM_MSB       = 5;
  localparam int         EPF_FLAG_BIT      = 7;
  // Table selectors
  localparam logic [1:0] EPF_TBL_COM       = 2'h0;
  localparam logic [1:0] EPF_TBL_WW        = 2'h1;
  localparam logic [1:0] EPF_TBL_BWR       = 2'h2;
  localparam int         EPF_FIFO_DEPTH    = 16;
  localparam int         EPF_PIXEL_BYTES   = 6512;
  // Level codes of the common table
  typedef enum logic [1:0] {
    EPF_COM_OFFSET = 2'h0, EPF_COM_HIGH = 2'h1,
    EPF_COM_LOW    = 2'h2, EPF_COM_FLOAT = 2'h3
  } epf_com_level_t;
  // Level codes of the source tables
  typedef enum logic [1:0] {
    EPF_SRC_GND = 2'h0, EPF_SRC_POS = 2'h1,
    EPF_SRC_NEG = 2'h2, EPF_SRC_RED_POS = 2'h3
  } epf_src_level_t;
  // Sequencer states
  typedef enum logic [5:0] {
    EPF_IDLE  = 6'h01, EPF_PON  = 6'h02, EPF_DRF   = 6'h04,
    EPF_POF   = 6'h08, EPF_DEEP_SLEEP_STEP = 6'h10, EPF_SLEEP = 6'h20
  } epf_seq_t;
endpackage : epf_pkg

// file: tb_epf_frame_lut.sv
// Self-checking bench for the frame load and waveform table block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end

module tb_epf_frame_lut import epf_pkg::*; ;
  localparam int PB = 20;
  logic sys_clk, sys_rst = 1'b1, host_valid = 1'b0, command_or_parameter_select = 1'b0;
  logic [7:0] host_byte = 8'h00, stop_status_q, rd_byte_q, rd_repeat_q, fm_data_q;
  logic colour_mode_select = 1'b1, busy_n_q, host_ready, step_done, fm_ready, stall = 1'b0;
  logic power_on_step_q, display_refresh_step_q, power_off_step_q, deep_sleep_step_q;
  logic fm_valid_q, fm_red_plane_q, rd_in_use_q, rd_com_float_q, saw_full = 1'b0;
  logic [15:0] fm_addr_q;
  logic [1:0] rd_tbl = 2'h0, rd_level_q;
  logic [2:0] rd_group = 3'h0, rd_item = 3'h0;
  logic [5:0] rd_frames_q;
  logic [3:0] groups_used_q, steps, step_prev = 4'h0, step_delay = 4'h1, es;
  logic [24:0] fm_q[$];
  logic [24:0] ef;
  logic [3:0] step_q[$];
  logic [7:0] tbl[3][56] = '{default: 8'h00};
  integer seed = 32'h3e213015;
  int fail_count = 0, comparisons = 0, cycles = 0;

  assign steps = {deep_sleep_step_q, power_off_step_q, display_refresh_step_q, power_on_step_q};

  // Clock at 200 MHz
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  epf_frame_lut #(.PIXEL_BYTES(PB)) dut (.sys_clk, .sys_rst, .host_valid,
    .command_or_parameter_select, .host_byte, .host_ready, .colour_mode_select, .busy_n_q,
    .stop_status_q, .power_on_step_q, .display_refresh_step_q, .power_off_step_q,
    .deep_sleep_step_q, .step_done, .fm_valid_q, .fm_ready, .fm_red_plane_q, .fm_addr_q,
    .fm_data_q, .rd_tbl, .rd_group, .rd_item, .rd_byte_q, .rd_level_q, .rd_frames_q,
    .rd_repeat_q, .rd_in_use_q, .rd_com_float_q, .groups_used_q);

  epf_panel_model panel (.sys_clk, .sys_rst, .stall, .step_delay, .steps, .step_done,
    .fm_ready);

  // Verdict and end of run
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  task automatic test_end(input string nm);
    $display("test %s done", nm);
  endtask : test_end

  // Offer one byte and hold it until taken
  task automatic send(input logic dc, input logic [7:0] b);
    int n;
    n = 0;
    host_valid <= 1'b1;
    command_or_parameter_select <= dc;
    host_byte <= b;
    do begin
      @(posedge sys_clk);
      n++;
    end while (host_ready !== 1'b1 && n < 300);
  endtask : send

  task automatic stop_host();
    host_valid <= 1'b0;
    @(posedge sys_clk);
  endtask : stop_host

  // Wait until all expected steps and writes have been seen
  task automatic wait_steps();
    int n;
    n = 0;
    while ((step_q.size() != 0 || steps !== 4'h0 || fm_q.size() != 0) && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 3000) `CHK("wait_done", 1'b0, 1'b1)
    @(posedge sys_clk);
    #1;
  endtask : wait_steps

  // Second frame load, then data stop
  task automatic frame(input logic m, input int n, input logic [7:0] flag);
    logic [7:0] b;
    colour_mode_select <= m;
    send(1'b0, EPF_CMD_FRAME2);
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      fm_q.push_back({~m, 16'(i), b}); // plane, address and byte
      send(1'b1, b); // byte count per frame
    end
    if (flag[7]) step_q.push_back(4'h2);
    send(1'b0, EPF_CMD_DATA_STOP); // stop after last byte
    stop_host();
    @(posedge sys_clk);
    #1;
    `CHK("stop_flag", flag, stop_status_q)
    wait_steps();
  endtask : frame

  // Automatic sequence with a second request, made while busy unless the code is unknown
  task automatic auto_run(input logic [7:0] code);
    step_delay <= {1'b0, 3'($random(seed))} + 4'h1;
    if (code == EPF_AUTO_REFRESH || code == EPF_AUTO_SLEEP) begin
      step_q.push_back(4'h1);
      step_q.push_back(4'h2);
      step_q.push_back(4'h4);
    end
    if (code == EPF_AUTO_SLEEP) step_q.push_back(4'h8);
    send(1'b0, EPF_CMD_AUTO);
    send(1'b1, code); // host waits only for host_ready, not for idle
    send(1'b0, EPF_CMD_AUTO);
    // Sleep request while busy after a refresh run, a repeat of the code otherwise
    send(1'b1, (code == EPF_AUTO_REFRESH) ? EPF_AUTO_SLEEP : code);
    stop_host();
    repeat (3) @(posedge sys_clk);
    wait_steps();
    `CHK("busy_after", 1'(code != EPF_AUTO_SLEEP), busy_n_q)
    test_end("auto");
  endtask : auto_run

  // Read one table item and compare every decoded field
  task automatic rd_chk(input int m, input int t, input int g, input int it);
    logic [7:0] b;
    logic [3:0] gu;
    logic ph;
    logic rp;
    rd_tbl <= 2'(t);
    rd_group <= 3'(g);
    rd_item <= 3'(it);
    @(posedge sys_clk);
    #1;
    b = (t == 3 || it == 7) ? 8'h00 : tbl[t][g*7+it];
    ph = it >= 1 && it <= 4;
    rp = it == 0 || it == 5 || it == 6;
    gu = t == 3 ? 4'h0 : t == 1 ? (m != 0 ? 4'h6 : 4'h0) : (m != 0 ? 4'h6 : 4'h8);
    `CHK("rd_byte", b, rd_byte_q)
    `CHK("rd_level", ph ? b[7:6] : 2'h0, rd_level_q)
    `CHK("rd_frames", ph ? b[5:0] : 6'h00, rd_frames_q)
    `CHK("rd_repeat", rp ? b : 8'h00, rd_repeat_q)
    `CHK("rd_in_use", 4'(g) < gu, rd_in_use_q)
    `CHK("groups_used", gu, groups_used_q)
    `CHK("com_float", t == 0 && ph && b[7:6] == 2'h3, rd_com_float_q)
  endtask : rd_chk

  // Load all three tables, overlong, then rewrite part of one
  task automatic tables();
    logic [7:0] b;
    for (int t = 0; t < 3; t++) begin
      send(1'b0, EPF_CMD_LUT_COM + 8'(t));
      for (int i = 0; i < 58; i++) begin
        b = 8'($random(seed));
        send(1'b1, b);
        if (i < (t == 1 ? 42 : 56)) tbl[t][i] = b; // table sizes
      end
    end
    send(1'b0, EPF_CMD_LUT_COM);
    for (int i = 0; i < 3; i++) begin
      b = 8'($random(seed));
      send(1'b1, b);
      tbl[0][i] = b; // rest kept
    end
    stop_host();
    for (int m = 0; m < 2; m++) begin
      colour_mode_select <= 1'(m);
      @(posedge sys_clk);
      for (int k = 0; k < 256; k++) rd_chk(m, k / 64, (k / 8) % 8, k % 8);
    end
    test_end("tables");
  endtask : tables

  // Timeout and scoreboards for frame writes and steps
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 30000) begin
      fail_count++;
      end_of_test();
    end
    if (host_valid && host_ready === 1'b0) saw_full = 1'b1;
    if (!sys_rst && fm_valid_q === 1'b1 && fm_ready) begin
      ef = fm_q.size() != 0 ? fm_q.pop_front() : 25'h1FFFFFF;
      `CHK("fm_write", ef, {fm_red_plane_q, fm_addr_q, fm_data_q})
    end
    if (!sys_rst && steps !== 4'h0 && steps !== step_prev) begin
      es = step_q.size() != 0 ? step_q.pop_front() : 4'hF;
      `CHK("step", es, steps)
    end
    step_prev = steps;
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK("rst_busy", 1'b1, busy_n_q)
    `CHK("rst_ready", 1'b1, host_ready)
    test_end("reset");
    frame(1'b1, PB, 8'h80);
    stall <= 1'b1;
    fork
      frame(1'b0, PB, 8'h80);
      begin
        repeat (60) @(posedge sys_clk);
        stall <= 1'b0;
      end
    join
    `CHK("fifo_full", 1'b1, saw_full)
    frame(1'b0, 3, 8'h00);
    test_end("frames");
    auto_run(EPF_AUTO_REFRESH);
    auto_run(8'h33);
    auto_run(EPF_AUTO_SLEEP);
    send(1'b0, EPF_CMD_FRAME2);
    send(1'b1, 8'h5A);
    stop_host();
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK("sleep_busy", 1'b0, busy_n_q)
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK("wake_busy", 1'b1, busy_n_q)
    test_end("sleep");
    tables();
    end_of_test();
  end
endmodule : tb_epf_frame_lut

`default_nettype wire
